// File: src/serial_xfer_pkg.sv
// serial_xfer_pkg: constants shared by the three-wire serial transfer engine
// assumes: included before the engine and its transmit buffer
package serial_xfer_pkg;
  localparam int          XFER_BITS      = 8;
  localparam int          CNT_W          = 4;
  localparam int          HALF_W         = 8;
  localparam logic [2:0]  SLAVE_CLK_SEL  = 3'h7;
  localparam logic [3:0]  LAST_SAMPLE    = 4'h7;
  localparam logic [3:0]  ALL_BITS       = 4'h8;
  localparam logic [3:0]  CNT_RST        = 4'h0;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam int          MSB_POS        = 7;
  localparam int          LSB_POS        = 0;
  localparam logic [7:0]  HALF_CYC_DEF   = 8'h04;
  localparam int          TXQ_DEPTH_DEF  = 2;
endpackage : serial_xfer_pkg

// File: src/tx_hold_buffer.sv
// tx_hold_buffer: small valid/ready queue in front of the transmit buffer
// assumes: one clock, asynchronous active-high reset
`timescale 1ns/100ps
module tx_hold_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } hold_state_t;

  hold_state_t s_ff, nxt_s;
  logic        push;
  logic        pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready  = (s_ff.cnt != CW'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data  = s_ff.mem[s_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp           = ptr_inc(s_ff.wp);
    end
    if (pop) begin
      nxt_s.rp = ptr_inc(s_ff.rp);
    end
    nxt_s.cnt = CW'(s_ff.cnt + CW'(push) - CW'(pop));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule : tx_hold_buffer

// File: src/serial_xfer_engine.sv
// serial_xfer_engine: eight-bit three-wire serial transfer engine, master or slave
// assumes: control bits are plain ports from the cpu side on clk; serial pins
// arrive asynchronously and are synchronised here
`timescale 1ns/100ps
module serial_xfer_engine #(
  parameter bit         HAS_SLAVE_SELECT = 1'b1,
  parameter logic [7:0] HALF_PERIOD_CYC  = serial_xfer_pkg::HALF_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       serial_port_enable,
  input  wire logic       transmit_mode_select,
  input  wire logic       slave_select_gate_enable,
  input  wire logic       clock_polarity_select,
  input  wire logic       data_phase_select,
  input  wire logic       bit_order_select,
  input  wire logic [2:0] clock_source_select,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       shift_reg_read,
  output logic [7:0]      serial_shift_register,
  output logic            transfer_active_flag,
  output logic            transfer_done_flag,
  input  wire logic       done_clear,
  input  wire logic       serial_clock_in,
  output logic            serial_clock_out,
  output logic            serial_clock_oe,
  output logic            serial_out_line,
  input  wire logic       serial_in_line,
  input  wire logic       slave_select_input
);
  import serial_xfer_pkg::*;

  typedef struct packed {
    logic             ss1;
    logic             ss2;
    logic             ck1;
    logic             ck2;
    logic             ck3;
    logic             si1;
    logic             si2;
    logic             active;
    logic             pending;
    logic             first;
    logic [CNT_W-1:0] cnt;
    logic [HALF_W-1:0] half;
    logic             sck;
    logic [7:0]       txbuf;
    logic [7:0]       sr;
    logic             so;
    logic             done;
  } xfer_state_t;

  xfer_state_t s_ff, nxt_s;

  logic       en;
  logic       master;
  logic       idle_lvl;
  logic       gate_on;
  logic       gate_ok;
  logic       suspend;
  logic [7:0] q_data;
  logic       q_valid;
  logic       q_pop;
  logic       rd_start;
  logic       start;
  logic       lead;
  logic       trail;
  logic       sample_evt;
  logic       drive_evt;
  logic       done_evt;
  logic       m_toggle;
  logic       dis_so;

  // bit that leaves the register next, per bit order
  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
    out_bit = lsb_first ? v[LSB_POS] : v[MSB_POS];
  endfunction : out_bit

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic din, input logic lsb_first);
    shift_in = lsb_first ? {din, v[7:1]} : {v[6:0], din};
  endfunction : shift_in

  tx_hold_buffer #(
    .W     (XFER_BITS),
    .DEPTH (TXQ_DEPTH_DEF)
  ) u_txq (
    .clk       (clk),
    .rst       (rst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_pop)
  );

  assign en       = serial_port_enable;
  assign master   = (clock_source_select != SLAVE_CLK_SEL);
  // clock idles high with polarity 0, low with polarity 1
  assign idle_lvl = ~clock_polarity_select;
  assign gate_on  = HAS_SLAVE_SELECT && slave_select_gate_enable && !master;
  assign gate_ok  = !gate_on || !s_ff.ss2;
  assign suspend  = gate_on && s_ff.ss2 && s_ff.active;

  // queue drains only into an idle engine, so writes stall rather than overwrite
  assign q_pop    = q_valid && en && transmit_mode_select && !s_ff.active && !s_ff.pending;
  assign rd_start = shift_reg_read && en && !transmit_mode_select && !s_ff.active && !s_ff.pending;
  assign start    = en && s_ff.pending && !s_ff.active && gate_ok;

  assign m_toggle = master && s_ff.active && (s_ff.half == HALF_PERIOD_CYC - 8'h01);
  always_comb begin
    lead  = 1'b0;
    trail = 1'b0;
    if (en && s_ff.active && !suspend) begin
      if (master) begin
        lead  = m_toggle && (s_ff.sck == idle_lvl);
        trail = m_toggle && (s_ff.sck != idle_lvl);
      end else if (s_ff.ck2 != s_ff.ck3) begin
        lead  = (s_ff.ck3 == idle_lvl);
        trail = (s_ff.ck3 != idle_lvl);
      end
    end
  end

  assign sample_evt = data_phase_select ? lead : trail;
  // phase 1 gives no new bit after the eighth sample, so the last bit stays
  assign drive_evt  = data_phase_select ? (trail && (s_ff.cnt != ALL_BITS)) : lead;
  assign done_evt   = (sample_evt && (s_ff.cnt == LAST_SAMPLE) && (!master || !data_phase_select))
                   || (master && data_phase_select && trail && (s_ff.cnt == ALL_BITS));

  always_comb begin
    nxt_s     = s_ff;
    nxt_s.ss1 = slave_select_input;
    nxt_s.ss2 = s_ff.ss1;
    nxt_s.ck1 = serial_clock_in;
    nxt_s.ck2 = s_ff.ck1;
    nxt_s.ck3 = s_ff.ck2;
    nxt_s.si1 = serial_in_line;
    nxt_s.si2 = s_ff.si1;
    if (!en) begin
      nxt_s.active  = 1'b0;
      nxt_s.pending = 1'b0;
      nxt_s.first   = 1'b0;
      nxt_s.cnt     = CNT_RST;
      nxt_s.half    = '0;
      nxt_s.sr      = BYTE_RST;
      nxt_s.so      = 1'b0;
    end else begin
      if (q_pop) begin
        nxt_s.txbuf   = q_data;
        nxt_s.pending = 1'b1;
        if (data_phase_select) begin
          nxt_s.so = out_bit(q_data, bit_order_select);
        end
      end
      if (rd_start) begin
        nxt_s.pending = 1'b1;
      end
      if (start) begin
        nxt_s.pending = 1'b0;
        nxt_s.active  = 1'b1;
        nxt_s.first   = 1'b1;
        nxt_s.cnt     = CNT_RST;
        nxt_s.half    = '0;
        nxt_s.sck     = idle_lvl;
      end
      if (master && s_ff.active) begin
        if (m_toggle) begin
          nxt_s.half = '0;
          nxt_s.sck  = ~s_ff.sck;
        end else begin
          nxt_s.half = HALF_W'(s_ff.half + 8'h01);
        end
      end
      if (drive_evt) begin
        nxt_s.so = out_bit(s_ff.first ? s_ff.txbuf : s_ff.sr, bit_order_select);
      end
      if (sample_evt && (s_ff.cnt != ALL_BITS)) begin
        // in transmit mode the first sample copies the transmit buffer in, then shifts
        nxt_s.sr    = shift_in((s_ff.first && transmit_mode_select) ? s_ff.txbuf : s_ff.sr,
                               s_ff.si2, bit_order_select);
        nxt_s.first = 1'b0;
        nxt_s.cnt   = CNT_W'(s_ff.cnt + 4'h1);
      end
      if (done_evt) begin
        nxt_s.active = 1'b0;
        nxt_s.cnt    = CNT_RST;
        nxt_s.sck    = idle_lvl;
      end
    end
    // set wins over clear
    if (done_evt) begin
      nxt_s.done = 1'b1;
    end else if (done_clear) begin
      nxt_s.done = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    if (!transmit_mode_select || !data_phase_select) begin
      dis_so = 1'b0;
    end else begin
      dis_so = out_bit(s_ff.txbuf, bit_order_select);
    end
  end

  assign serial_out_line       = !en ? dis_so : (transmit_mode_select ? s_ff.so : 1'b0);
  assign serial_clock_out      = (master && s_ff.active) ? s_ff.sck : idle_lvl;
  assign serial_clock_oe       = en && master;
  assign serial_shift_register = s_ff.sr;
  assign transfer_active_flag  = s_ff.active && en;
  assign transfer_done_flag    = s_ff.done;

  property p_start_active;
    @(posedge clk) disable iff (rst) start |=> transfer_active_flag || !en;
  endproperty
  a_start_active: assert property (p_start_active) else $error("start did not raise active");

  property p_done;
    @(posedge clk) disable iff (rst) done_evt |=> transfer_done_flag && !s_ff.active;
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_gate_block;
    @(posedge clk) disable iff (rst) (gate_on && s_ff.ss2 && !s_ff.active) |=> !s_ff.active;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("started with slave select high");

  property p_pending_start;
    @(posedge clk) disable iff (rst)
      (en && s_ff.pending && gate_ok && !s_ff.active) ##1 en |-> s_ff.active && !s_ff.pending;
  endproperty
  a_pending_start: assert property (p_pending_start) else $error("pending request not started");

  property p_suspend;
    @(posedge clk) disable iff (rst) (suspend && en) |=> $stable(s_ff.sr) && $stable(s_ff.cnt);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspended transfer moved");

  property p_sticky;
    @(posedge clk) disable iff (rst) (transfer_done_flag && !done_clear) |=> transfer_done_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag dropped on its own");

  property p_hold_last;
    @(posedge clk) disable iff (rst)
      (en && transmit_mode_select && !s_ff.active && !q_pop && !start) ##1 en |-> $stable(serial_out_line);
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("serial out changed while idle");

  property p_disable;
    @(posedge clk) disable iff (rst) !en |=> !s_ff.active && (s_ff.sr == BYTE_RST);
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not reset engine");

  property p_idle_clock;
    @(posedge clk) disable iff (rst) (done_evt && master) |=> serial_clock_out == idle_lvl;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock not idle after transfer");

  property p_first_dap1;
    @(posedge clk) disable iff (rst)
      (q_pop && data_phase_select) ##1 (en && transmit_mode_select) |-> s_ff.so == out_bit(s_ff.txbuf, bit_order_select);
  endproperty
  a_first_dap1: assert property (p_first_dap1) else $error("phase 1 first bit not driven");

  property p_cnt_range;
    @(posedge clk) disable iff (rst) s_ff.cnt <= ALL_BITS;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("bit count past eight");

  property p_tx_load;
    @(posedge clk) disable iff (rst) q_pop |=> s_ff.pending && (s_ff.txbuf == $past(q_data));
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("transmit byte not loaded");

  property p_read_start;
    @(posedge clk) disable iff (rst) rd_start |=> s_ff.pending;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read did not request reception");

  property p_first_dap0;
    @(posedge clk) disable iff (rst)
      (drive_evt && !data_phase_select && s_ff.first) |=> s_ff.so == out_bit(s_ff.txbuf, bit_order_select);
  endproperty
  a_first_dap0: assert property (p_first_dap0) else $error("phase 0 first bit not from buffer");

  property p_first_load;
    @(posedge clk) disable iff (rst)
      (sample_evt && s_ff.first && transmit_mode_select && (s_ff.cnt != ALL_BITS)) |=>
        s_ff.sr == shift_in($past(s_ff.txbuf), $past(s_ff.si2), $past(bit_order_select));
  endproperty
  a_first_load: assert property (p_first_load) else $error("first sample did not load buffer");

  property p_idle_so_low;
    @(posedge clk) disable iff (rst) (!en && (!transmit_mode_select || !data_phase_select)) |-> !serial_out_line;
  endproperty
  a_idle_so_low: assert property (p_idle_so_low) else $error("disabled serial out not low");

  property p_next_accept;
    @(posedge clk) disable iff (rst)
      (done_evt && q_valid && transmit_mode_select) ##1 (en && transmit_mode_select) |-> q_pop;
  endproperty
  a_next_accept: assert property (p_next_accept) else $error("next byte not accepted");

  c_master_done: cover property (@(posedge clk) disable iff (rst) done_evt && master);
  c_slave_done: cover property (@(posedge clk) disable iff (rst) done_evt && !master);
  c_suspend: cover property (@(posedge clk) disable iff (rst) suspend && en);
  c_gated_wait: cover property (@(posedge clk) disable iff (rst) s_ff.pending && !gate_ok ##1 start);
endmodule : serial_xfer_engine

// File: tb/serial_peer_model.sv
// serial_peer_model: far-side peer, slave on the engine clock or clock master
// assumes: the bench resolves the clock wire and calls arm and run
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic clk,
  input  wire logic sck_wire,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic lsbf,
  input  wire logic mosi,
  output logic      miso,
  output logic      sck_drive
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] cur = 8'h00;
  logic [7:0] got = 8'h00;
  logic       busy = 1'b0;
  logic       alt = 1'b0;
  int         k = 0;
  int         n = 0;
  int         i;
  initial sck_drive = 1'b1;
  task arm(input logic [7:0] b);
    tx_q.push_back(b);
    if (!busy) begin
      cur = tx_q.pop_front();
      k = 0;
      n = 0;
      busy = 1'b1;
    end
  endtask : arm
  // clock only within frames, 48 ns period
  task run(input int pulses);
    repeat (pulses) begin
      #24 sck_drive = cpol;
      #24 sck_drive = ~cpol;
    end
  endtask : run
  // a released line shows a pattern that changes every cycle
  always @(posedge clk) alt <= ~alt;
  always @(posedge sck_wire or negedge sck_wire) begin
    if (busy) begin
      if ((sck_wire == cpol) != cpha) k = k + 1;
      else begin
        got[lsbf ? n : 7 - n] = mosi;
        n = n + 1;
        if (n == 8) begin
          rx_q.push_back(got);
          busy = tx_q.size() > 0;
          if (busy) cur = tx_q.pop_front();
          n = 0;
          k = cpha ? -1 : 0;
        end
      end
    end
  end
  always @* begin
    i = cpha ? k : k - 1;
    if (i < 0) i = 0;
    miso = busy ? cur[lsbf ? i : 7 - i] : alt;
  end
endmodule : serial_peer_model

// File: tb/three_wire_serial_transfer_bench.sv
// three_wire_serial_transfer_bench: self-checking bench of the serial transfer engine
// assumes: package, engine and peer model compiled first
`timescale 1ns/100ps
module three_wire_serial_transfer_bench;
  import serial_xfer_pkg::*;
  logic        clk, rst, en, tmode, gate, cpol, cpha, lsbf, rd, dclr, ssn, tx_valid;
  logic [2:0]  cks;
  logic [7:0]  txd, sr, last_b;
  logic        tx_ready, act, done, sck_out, sck_oe, so, si, sck_drive, sck_wire;
  logic [7:0]  exp_sr[$], exp_peer[$];
  logic        exp_so[$];
  logic [31:0] seed = 32'hb7a4;
  int          err_count = 0, n_compared = 0, cycles = 0, pulses = 0;
  assign sck_wire = sck_oe ? sck_out : sck_drive;
  serial_xfer_engine #(.HAS_SLAVE_SELECT(1'b1), .HALF_PERIOD_CYC(8'h04)) i_serial_xfer_engine (
    .clk(clk), .rst(rst), .serial_port_enable(en), .transmit_mode_select(tmode),
    .slave_select_gate_enable(gate), .clock_polarity_select(cpol), .data_phase_select(cpha),
    .bit_order_select(lsbf), .clock_source_select(cks), .tx_data(txd), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .shift_reg_read(rd), .serial_shift_register(sr), .transfer_active_flag(act),
    .transfer_done_flag(done), .done_clear(dclr), .serial_clock_in(sck_wire),
    .serial_clock_out(sck_out), .serial_clock_oe(sck_oe), .serial_out_line(so),
    .serial_in_line(si), .slave_select_input(ssn));
  serial_peer_model i_serial_peer_model (.clk(clk), .sck_wire(sck_wire), .cpol(cpol), .cpha(cpha),
    .lsbf(lsbf), .mosi(so), .miso(si), .sck_drive(sck_drive));
  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task summarize();
    $display("comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  // queue what the engine and the peer should see for one frame
  task plan(input logic [7:0] b);
    logic [7:0] p;
    p = rnd();
    exp_sr.push_back(p);
    exp_peer.push_back(tmode ? b : 8'h00);
    exp_so.push_back(tmode & (lsbf ? b[7] : b[0]));
    i_serial_peer_model.arm(p);
  endtask : plan
  task send(input int cnt);
    logic [7:0] f;
    f = rnd();
    last_b = f;
    pulses = 0;
    for (int j = 0; j < cnt; j++) begin
      txd <= j ? rnd() : f;
      tx_valid <= 1'b1;
      @(negedge clk);
      plan(txd);
      while (tx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    tx_valid <= 1'b0;
    @(negedge clk);
    chk(8'(tx_ready), 8'(cnt < 3));
    // the first byte reaches the transmit buffer one edge after it is queued
    @(negedge clk);
    if (cpha) chk(8'(so), 8'(lsbf ? f[0] : f[7]));
    @(posedge clk);
  endtask : send
  task frame_end();
    int t;
    t = 0;
    while (act !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    while (act !== 1'b0 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    // look before a queued phase 1 byte replaces the held last bit
    chk(8'(t < 3000), 8'h01);
    chk(sr, exp_sr.pop_front());
    chk(i_serial_peer_model.rx_q.pop_front(), exp_peer.pop_front());
    chk(8'(done), 8'h01);
    chk(8'(so), 8'(exp_so.pop_front()));
    chk(8'(pulses), 8'h08);
    chk(8'(sck_oe), 8'(cks != SLAVE_CLK_SEL));
    if (cks != SLAVE_CLK_SEL) chk(8'(sck_out), 8'(!cpol));
    pulses = 0;
    @(posedge clk);
  endtask : frame_end
  always @(posedge sck_wire or negedge sck_wire) if (sck_wire === cpol) pulses++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, tmode, ssn} = 3'h7;
    {en, gate, cpol, cpha, lsbf, rd, dclr, tx_valid} = 8'h00;
    cks = 3'h0;
    txd = 8'h00;
    cyc(6);
    rst <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      en <= 1'b0;
      {cpol, cpha, lsbf} <= m[2:0];
      cks <= 3'(rnd() % 8'd7);
      cyc(3);
      en <= 1'b1;
      cyc(3);
      send(3);
      repeat (3) frame_end();
    end
    en <= 1'b0;
    tmode <= 1'b0;
    cyc(3);
    en <= 1'b1;
    cyc(3);
    pulses = 0;
    plan(8'h00);
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    frame_end();
    en <= 1'b0;
    {tmode, gate, cpol, cpha, lsbf} <= 5'h18;
    cks <= 3'h7;
    cyc(3);
    en <= 1'b1;
    cyc(3);
    send(1);
    cyc(20);
    @(negedge clk);
    chk(8'(act), 8'h00);
    @(posedge clk);
    ssn <= 1'b0;
    cyc(12);
    @(negedge clk);
    chk(8'(act), 8'h01);
    chk(8'(done), 8'h01);
    @(posedge clk);
    dclr <= 1'b1;
    cyc(1);
    dclr <= 1'b0;
    i_serial_peer_model.run(4);
    cyc(4);
    ssn <= 1'b1;
    cyc(30);
    @(negedge clk);
    chk(8'(act), 8'h01);
    chk(8'(done), 8'h00);
    @(posedge clk);
    ssn <= 1'b0;
    cyc(12);
    i_serial_peer_model.run(4);
    frame_end();
    en <= 1'b0;
    {tmode, gate, cpha, lsbf} <= 4'ha;
    cks <= 3'h1;
    cyc(3);
    en <= 1'b1;
    cyc(3);
    send(1);
    cyc(10);
    en <= 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(act), 8'h00);
    chk(sr, 8'h00);
    chk(8'(so), 8'(last_b[7]));
    @(posedge clk);
    lsbf <= 1'b1;
    @(negedge clk);
    chk(8'(so), 8'(last_b[0]));
    @(posedge clk);
    tmode <= 1'b0;
    @(negedge clk);
    chk(8'(so), 8'h00);
    summarize();
  end
endmodule : three_wire_serial_transfer_bench
